// [rbv_pkg.sv]
// constants for the reset and boot vector select block
// Behaviour
// - core fetch halted while reset held
// - registers defaulted; power-on-only bits kept otherwise
// - interrupts disabled and timers stopped in reset
// - ram contents untouched by any reset
// - port latches set to one, open-drain
// - weak pull-ups on during and after reset
// - power-on or supply reset drives pin low
// - exit clears program counter, internal oscillator
// - watchdog enabled on exit without software
// - no bootloader: start at address zero
// - nine sources each enter reset state
// - signature byte below lock byte, a5 present
// - bootloader present: start at bootloader vector
// - bootloader occupies last three flash pages
// - watchdog starts with longest timeout
// - default clock 48 MHz divided 4 then 8
package rbv_pkg;
  // reset source indices
  localparam int unsigned SRC_POR    = 0;
  localparam int unsigned SRC_PIN    = 1;
  localparam int unsigned SRC_CMP    = 2;
  localparam int unsigned SRC_SW     = 3;
  localparam int unsigned SRC_VMON   = 4;
  localparam int unsigned SRC_WDOG   = 5;
  localparam int unsigned SRC_MCLK   = 6;
  localparam int unsigned SRC_FLASH  = 7;
  localparam int unsigned SRC_USB    = 8;
  localparam int unsigned NUM_SRC    = 9;
  // boot decision values
  localparam logic [7:0]  BOOT_SIG_PRESENT = 8'ha5;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam int unsigned BOOT_PAGES       = 3;
  // clock selection after reset
  localparam logic [1:0]  CLK_SEL_INT_OSC  = 2'h0;
  localparam logic [1:0]  CLK_DIV_PRE      = 2'h2;
  localparam logic [2:0]  CLK_DIV_POST     = 3'h3;
  // watchdog default interval code (longest)
  localparam logic [2:0]  WDOG_INTERVAL_MAX = 3'h7;
  // port latch reset value
  localparam logic        PORT_LATCH_RESET = 1'b1;
  // release stretch in cycles after all sources clear
  localparam int unsigned RELEASE_CYCLES   = 4;
  // exit sequencer states
  typedef enum logic [1:0] {RBV_HOLD, RBV_STRETCH, RBV_LOAD, RBV_RUN} rbv_state_t;
endpackage

// [rbv_reset_ctrl.sv]
// reset sequencer with boot vector selection
`timescale 1ns/100ps
module rbv_reset_ctrl #(
  parameter int unsigned PORT_BITS  = 40,
  parameter int unsigned FLASH_AW   = 16,
  parameter int unsigned PAGE_BYTES = 512,
  parameter logic [15:0] LOCK_ADDR  = 16'hfbff
) (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  // reset sources, active high levels except the pin
  input  wire logic                 i_por_req,
  input  wire logic                 i_external_reset_pin_n,
  input  wire logic                 i_cmp_req,
  input  wire logic                 i_sw_req,
  input  wire logic                 i_vmon_req,
  input  wire logic                 i_wdog_overflow,
  input  wire logic                 i_missing_clk,
  input  wire logic                 i_flash_err,
  input  wire logic                 i_usb_bus_reset,
  // flash signature read
  input  wire logic [7:0]           i_sig_byte,
  // reset pin drive, low enable while driving
  output logic                      o_external_reset_pin_n,
  output logic                      o_reset_pin_oe_n,
  // core and peripheral controls
  output logic                      o_core_run,
  output logic                      o_periph_reset,
  output logic                      o_por_only_reset,
  output logic                      o_irq_enable,
  output logic                      o_timer_enable,
  output logic                      o_ram_write_block,
  output logic [PORT_BITS-1:0]      o_port_latch,
  output logic [PORT_BITS-1:0]      o_port_push_pull,
  output logic                      o_weak_pullup_en,
  output logic [FLASH_AW-1:0]       o_sig_addr,
  output logic [15:0]               o_program_counter,
  output logic                      o_boot_to_loader,
  output logic [1:0]                o_system_clock_sel,
  output logic [1:0]                o_clk_div_pre,
  output logic [2:0]                o_clk_div_post,
  output logic                      o_watchdog_enable,
  output logic [2:0]                o_watchdog_interval,
  output logic [rbv_pkg::NUM_SRC-1:0] o_last_cause
);

  // elaboration checks on parameters
  if (PORT_BITS < 1 || FLASH_AW < 16 || PAGE_BYTES < 1 ||
      rbv_pkg::RELEASE_CYCLES < 1 || rbv_pkg::RELEASE_CYCLES > 16 ||
      32'(LOCK_ADDR) + 32'd1 < rbv_pkg::BOOT_PAGES * PAGE_BYTES) begin : g_bad
    $error("rbv_reset_ctrl: unsupported parameter value");
  end

  // bootloader base sits three pages below the top of flash
  localparam logic [15:0] BOOT_VECTOR =
      16'(32'(LOCK_ADDR) + 32'd1 - rbv_pkg::BOOT_PAGES * PAGE_BYTES);
  localparam int unsigned CNT_W = 4;

  // synchronisers for all nine source inputs: three stages
  logic [rbv_pkg::NUM_SRC-1:0] raw_src;
  logic [rbv_pkg::NUM_SRC-1:0] sync1_q;
  logic [rbv_pkg::NUM_SRC-1:0] sync2_q;
  logic [rbv_pkg::NUM_SRC-1:0] sync3_q;
  logic [rbv_pkg::NUM_SRC-1:0] src_q;    // filtered source levels
  logic                        any_src;
  rbv_pkg::rbv_state_t         state_q;
  logic [CNT_W-1:0]            cnt_q;    // release stretch counter
  logic                        drive_pin_q;
  logic                        in_reset;

  // gather sources; the pin is active low
  // all nine sources
  always_comb begin
    raw_src                     = '0;
    raw_src[rbv_pkg::SRC_POR]   = i_por_req;
    // own pull-down on the pin must not hold the block in reset for ever
    raw_src[rbv_pkg::SRC_PIN]   = ~i_external_reset_pin_n & ~drive_pin_q;
    raw_src[rbv_pkg::SRC_CMP]   = i_cmp_req;
    raw_src[rbv_pkg::SRC_SW]    = i_sw_req;
    raw_src[rbv_pkg::SRC_VMON]  = i_vmon_req;
    raw_src[rbv_pkg::SRC_WDOG]  = i_wdog_overflow;
    raw_src[rbv_pkg::SRC_MCLK]  = i_missing_clk;
    raw_src[rbv_pkg::SRC_FLASH] = i_flash_err;
    raw_src[rbv_pkg::SRC_USB]   = i_usb_bus_reset;
  end

  // three-stage chain, filter takes a change when stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= raw_src;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // per-source agreement filter
  generate
    for (genvar g = 0; g < rbv_pkg::NUM_SRC; g++) begin : g_filt
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          src_q[g] <= 1'b1;                 // power-up counts as held reset
        end else if (sync2_q[g] == sync3_q[g]) begin
          src_q[g] <= sync3_q[g];
        end
      end
    end
  endgenerate

  assign any_src  = |src_q;
  assign in_reset = (state_q != rbv_pkg::RBV_RUN);

  // exit sequencer: hold, stretch, load vector, run
  // synchronous release
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= rbv_pkg::RBV_HOLD;
      cnt_q   <= '0;
    end else if (any_src) begin
      // any source restarts the hold
      state_q <= rbv_pkg::RBV_HOLD;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        rbv_pkg::RBV_HOLD: begin
          state_q <= rbv_pkg::RBV_STRETCH;
          cnt_q   <= '0;
        end
        rbv_pkg::RBV_STRETCH: begin
          if (cnt_q == CNT_W'(rbv_pkg::RELEASE_CYCLES - 1)) begin
            state_q <= rbv_pkg::RBV_LOAD;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        rbv_pkg::RBV_LOAD: begin
          state_q <= rbv_pkg::RBV_RUN;
        end
        rbv_pkg::RBV_RUN: begin
          state_q <= rbv_pkg::RBV_RUN;
        end
        default: begin
          state_q <= rbv_pkg::RBV_HOLD;
        end
      endcase
    end
  end

  // latch which sources caused the reset, cleared on next entry
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_last_cause <= '0;
    end else if (any_src) begin
      o_last_cause <= (state_q == rbv_pkg::RBV_RUN) ? src_q : (o_last_cause | src_q);
    end
  end

  // pin drive for power-on and supply monitor resets
  // drive pin low
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drive_pin_q <= 1'b1;
    end else if (src_q[rbv_pkg::SRC_POR] || src_q[rbv_pkg::SRC_VMON]) begin
      drive_pin_q <= 1'b1;
    end else if ((state_q == rbv_pkg::RBV_LOAD) || (state_q == rbv_pkg::RBV_RUN)) begin
      // let go as the core starts running
      drive_pin_q <= 1'b0;
    end
  end

  // open-drain pin: output low, enable low while driving
  assign o_external_reset_pin_n = 1'b0;
  assign o_reset_pin_oe_n       = ~drive_pin_q;

  // core halt and register defaults
  // core halted
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_core_run       <= 1'b0;
      o_periph_reset   <= 1'b1;
      o_por_only_reset <= 1'b1;
    end else begin
      o_core_run       <= (state_q == rbv_pkg::RBV_LOAD) || (state_q == rbv_pkg::RBV_RUN);
      // register defaults
      // released on the same edge as the core starts
      o_periph_reset   <= in_reset && (state_q != rbv_pkg::RBV_LOAD);
      o_por_only_reset <= src_q[rbv_pkg::SRC_POR];
    end
  end

  // interrupts, timers and ram protection
  // interrupts and timers off
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_enable      <= 1'b0;
      o_timer_enable    <= 1'b0;
      o_ram_write_block <= 1'b1;
    end else begin
      o_irq_enable      <= ~in_reset;
      o_timer_enable    <= ~in_reset;
      o_ram_write_block <= in_reset;
    end
  end

  // port latches and pull-ups
  // latches to one
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_port_latch     <= {PORT_BITS{rbv_pkg::PORT_LATCH_RESET}};
      o_port_push_pull <= '0;
    end else if (in_reset) begin
      o_port_latch     <= {PORT_BITS{rbv_pkg::PORT_LATCH_RESET}};
      o_port_push_pull <= '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_weak_pullup_en <= 1'b1;
    end else begin
      o_weak_pullup_en <= 1'b1;
    end
  end

  // signature address: byte just below the lock byte
  // signature location
  assign o_sig_addr = FLASH_AW'(LOCK_ADDR - 16'h0001);

  // program counter and boot vector, loaded once on exit
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_program_counter <= rbv_pkg::PC_RESET;
      o_boot_to_loader  <= 1'b0;
    end else if (state_q == rbv_pkg::RBV_LOAD) begin
      if (i_sig_byte == rbv_pkg::BOOT_SIG_PRESENT) begin
        o_program_counter <= BOOT_VECTOR;
        o_boot_to_loader  <= 1'b1;
      end else begin
        o_program_counter <= rbv_pkg::RESET_VECTOR;
        o_boot_to_loader  <= 1'b0;
      end
    end else if (in_reset) begin
      o_program_counter <= rbv_pkg::PC_RESET;
    end
  end

  // default clock and watchdog on exit
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_system_clock_sel  <= rbv_pkg::CLK_SEL_INT_OSC;
      o_clk_div_pre       <= rbv_pkg::CLK_DIV_PRE;
      o_clk_div_post      <= rbv_pkg::CLK_DIV_POST;
      o_watchdog_enable   <= 1'b0;
      o_watchdog_interval <= rbv_pkg::WDOG_INTERVAL_MAX;
    end else if (in_reset) begin
      o_system_clock_sel  <= rbv_pkg::CLK_SEL_INT_OSC;
      o_clk_div_pre       <= rbv_pkg::CLK_DIV_PRE;
      o_clk_div_post      <= rbv_pkg::CLK_DIV_POST;
      o_watchdog_enable   <= (state_q == rbv_pkg::RBV_LOAD);
      o_watchdog_interval <= rbv_pkg::WDOG_INTERVAL_MAX;
    end
  end

endmodule

// [rbv_pin_model.sv]
// reset pin partner: button press on a pulled-up open-drain line
`timescale 1ns/100ps
module rbv_pin_model (
  // clock
  input  wire logic i_sys_clk,
  // press request and device pull-down enable
  input  wire logic i_hold,
  input  wire logic i_oe_n,
  // wired pin level
  output logic      o_pin_n
);
  logic [3:0] cnt_q = 4'h0;  // press stretch counter
  always_ff @(posedge i_sys_clk) begin
    if (i_hold) begin
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // pulled up unless either party pulls low
  assign o_pin_n = !(i_hold || (cnt_q != 4'h0) || !i_oe_n);
endmodule

// [rbv_reset_chk.sv]
// concurrent checks on reset entry, hold and boot exit
`timescale 1ns/100ps
module rbv_reset_chk #(
  parameter int unsigned PORT_BITS  = 40,
  parameter int unsigned FLASH_AW   = 16,
  parameter int unsigned PAGE_BYTES = 512,
  parameter logic [15:0] LOCK_ADDR  = 16'hfbff
) (
  // clock, reset and sources
  input wire logic                 i_sys_clk,
  input wire logic                 i_reset_n,
  input wire logic                 i_por_req,
  input wire logic                 i_external_reset_pin_n,
  input wire logic                 i_cmp_req,
  input wire logic                 i_sw_req,
  input wire logic                 i_vmon_req,
  input wire logic                 i_wdog_overflow,
  input wire logic                 i_missing_clk,
  input wire logic                 i_flash_err,
  input wire logic                 i_usb_bus_reset,
  input wire logic [7:0]           i_sig_byte,
  // watched outputs
  input wire logic                 o_reset_pin_oe_n,
  input wire logic                 o_external_reset_pin_n,
  input wire logic                 o_por_only_reset,
  input wire logic                 o_core_run,
  input wire logic                 o_periph_reset,
  input wire logic                 o_irq_enable,
  input wire logic                 o_timer_enable,
  input wire logic                 o_ram_write_block,
  input wire logic [PORT_BITS-1:0] o_port_latch,
  input wire logic [PORT_BITS-1:0] o_port_push_pull,
  input wire logic                 o_weak_pullup_en,
  input wire logic [FLASH_AW-1:0]  o_sig_addr,
  input wire logic [15:0]          o_program_counter,
  input wire logic                 o_boot_to_loader,
  input wire logic [1:0]           o_system_clock_sel,
  input wire logic [1:0]           o_clk_div_pre,
  input wire logic [2:0]           o_clk_div_post,
  input wire logic                 o_watchdog_enable,
  input wire logic [2:0]           o_watchdog_interval
);
  localparam logic [15:0] BOOT_VEC = LOCK_ADDR + 16'h0001 - 16'(rbv_pkg::BOOT_PAGES * PAGE_BYTES);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // any source asking for reset
  // a low pin counts only while the device itself is not pulling it
  wire any_src = i_por_req | (!i_external_reset_pin_n && o_reset_pin_oe_n)
                 | i_cmp_req | i_sw_req | i_vmon_req
                 | i_wdog_overflow | i_missing_clk | i_flash_err | i_usb_bus_reset;
  logic [3:0] quiet_q;  // cycles since last source, saturating
  // quiet time counter
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quiet_q <= 4'h0;
    end else if (any_src) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence src_held;
    any_src [*4];
  endsequence
  sequence supply_held;
    (i_por_req | i_vmon_req) [*4];
  endsequence
  sequence por_held;
    i_por_req [*4];
  endsequence
  sequence por_quiet;
    (!i_por_req) [*6];
  endsequence
  AST_CORE_HALT: assert property (o_periph_reset |-> !o_core_run)
    else $error("core running in reset");
  AST_INT_OFF: assert property (o_periph_reset |-> !o_irq_enable && !o_timer_enable)
    else $error("irq or timer on in reset");
  AST_RAM_KEEP: assert property (o_periph_reset |-> o_ram_write_block)
    else $error("ram writable in reset");
  AST_PORT_RST: assert property (o_periph_reset |-> &o_port_latch && o_port_push_pull == '0)
    else $error("port latches not preset");
  AST_PULLUP: assert property (o_weak_pullup_en)
    else $error("pull-ups off");
  AST_PIN_DRIVE: assert property (supply_held |-> ##[0:3] !o_reset_pin_oe_n)
    else $error("pin not driven on supply reset");
  AST_PIN_DATA: assert property (o_external_reset_pin_n == 1'b0)
    else $error("pin data not low");
  AST_POR_BITS: assert property (por_held |-> ##[0:3] o_por_only_reset)
    else $error("power-on-only reset missing");
  AST_POR_KEEP: assert property (por_quiet |-> ##[0:3] !o_por_only_reset)
    else $error("power-on-only bits reset by other source");
  AST_ENTER: assert property (src_held |-> ##[0:3] o_periph_reset)
    else $error("source did not enter reset");
  AST_RELEASE: assert property ($rose(o_core_run) |-> quiet_q >= 4'h6)
    else $error("released while source recent");
  AST_EXIT: assert property ($rose(o_core_run) |-> o_watchdog_enable
      && o_watchdog_interval == 3'h7 && o_system_clock_sel == 2'h0 && o_clk_div_pre == 2'h2
      && o_clk_div_post == 3'h3) else $error("exit defaults wrong");
  AST_VECTOR: assert property ($rose(o_core_run) |-> o_boot_to_loader == (i_sig_byte == 8'ha5)
      && o_program_counter == (o_boot_to_loader ? BOOT_VEC : 16'h0000)
      && o_sig_addr == FLASH_AW'(LOCK_ADDR - 16'h0001)) else $error("boot vector wrong");
endmodule
bind rbv_reset_ctrl rbv_reset_chk #(.PORT_BITS(PORT_BITS), .FLASH_AW(FLASH_AW),
  .PAGE_BYTES(PAGE_BYTES), .LOCK_ADDR(LOCK_ADDR)) rbv_reset_chk_inst (.*);

// [test_reset_and_boot_vector_select.sv]
// random and corner reset episodes across every source
`timescale 1ns/100ps
module test_reset_and_boot_vector_select;
  logic        i_sys_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [8:0]  req       = 9'h000;  // source levels, package order
  logic [7:0]  sig       = 8'h00;   // signature byte
  logic        pin_n, oe_n, run, boot, wd_en;
  logic [15:0] pc;
  logic [8:0]  cause;
  logic [1:0]  csel, dpre;
  logic [2:0]  dpost, wd_iv;
  integer      seed        = 31;
  int          err_count   = 0;
  int          check_count = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  rbv_pin_model rbv_pin_model_inst (.i_sys_clk(i_sys_clk), .i_hold(req[1]), .i_oe_n(oe_n),
    .o_pin_n(pin_n));
  rbv_reset_ctrl rbv_reset_ctrl_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_por_req(req[0]), .i_external_reset_pin_n(pin_n), .i_cmp_req(req[2]), .i_sw_req(req[3]),
    .i_vmon_req(req[4]), .i_wdog_overflow(req[5]), .i_missing_clk(req[6]),
    .i_flash_err(req[7]), .i_usb_bus_reset(req[8]), .i_sig_byte(sig),
    .o_external_reset_pin_n(), .o_reset_pin_oe_n(oe_n), .o_core_run(run), .o_periph_reset(),
    .o_por_only_reset(), .o_irq_enable(), .o_timer_enable(), .o_ram_write_block(),
    .o_port_latch(), .o_port_push_pull(), .o_weak_pullup_en(), .o_sig_addr(),
    .o_program_counter(pc), .o_boot_to_loader(boot), .o_system_clock_sel(csel),
    .o_clk_div_pre(dpre), .o_clk_div_post(dpost), .o_watchdog_enable(wd_en),
    .o_watchdog_interval(wd_iv), .o_last_cause(cause));
  // expected start address from signature
  function automatic logic [15:0] exp_pc(input logic [7:0] s);
    return (s == 8'ha5) ? 16'hfc00 - 16'h0600 : 16'h0000;
  endfunction
  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for core run level
  task automatic wait_run(input logic want);
    for (int n = 0; run !== want; n++) begin
      if (n > 300) begin
        err_count++;
        test_done();
      end
      @(posedge i_sys_clk);
      #1;
    end
  endtask
  // one reset episode from source s
  task automatic episode(input int s, input int len, input logic [7:0] sb);
    @(posedge i_sys_clk);
    sig    <= sb;
    req[s] <= 1'b1;
    #1;
    wait_run(1'b0);
    repeat (len) @(posedge i_sys_clk);
    #1;
    cmp("core_run", 16'h0000, {15'h0, run});
    cmp("pin_oe_n", {15'h0, !(s == 0 || s == 4)}, {15'h0, oe_n});
    cmp("cause", 16'h0001, {15'h0, cause[s]});
    @(posedge i_sys_clk);
    req[s] <= 1'b0;
    #1;
    wait_run(1'b1);
    cmp("pc", exp_pc(sb), pc);
    cmp("boot", {15'h0, sb == 8'ha5}, {15'h0, boot});
    cmp("clock", 16'h0013, {9'h0, csel, dpre, dpost});
    cmp("wdog", 16'h000f, {12'h0, wd_en, wd_iv});
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1;
    wait_run(1'b1);
    cmp("pc", exp_pc(8'h00), pc);
    for (int s = 0; s < 9; s++) episode(s, 1, 8'ha5);
    for (int s = 0; s < 9; s++) episode(s, 8, 8'ha4);
    for (int k = 0; k < 40; k++) episode({$random(seed)} % 9, 1 + {$random(seed)} % 12,
      (k % 2 == 0) ? 8'ha5 : 8'($random(seed)));
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1;
    wait_run(1'b1);
    cmp("pc", exp_pc(sig), pc);
    test_done();
  end
endmodule
